// *** inc/sdb_cfg.svh ***
// Constants for the second serial controller DMA buffer block
//
// Contract
// - Rx B start: 13-bit address, bits 14:13 one
// - Rx B end: 13-bit address, same upper bits
// - Tx A start address, fetch begins here
// - Tx A end address, buffer finishes here
// - Tx B start address, fetch begins here
// - Tx B end address, buffer finishes here
// - Rx A first error offset, zero if none
// - Rx B first error offset, zero if none
// - Later errors keep captured offset
// - Capture re-arms on reload or rx reset
// - Enable bits 12..9 gate DMA unload events
// - Enable bits 8..5 gate two-wire bus events
// - Enable bits 4..0 gate FIFO/transmitter events
// - Enable resets zero, bits 15..13 read zero
// - Events set pending flag, same bit position
// - Rx byte counter wraps to zero on unload
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SDB_AW 13
`define SDB_DW 16
`define SDB_BW 8
`define SDB_NEV 13
`define SDB_NEXT 9
`define SDB_FIFO_W 9
`define SDB_FIFO_D 4
`define SDB_FIFO_PW 2

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SDB_OFF_RXA_START 16'h4400
`define SDB_OFF_RXA_END 16'h4402
`define SDB_OFF_RXB_START 16'h4404
`define SDB_OFF_RXB_END 16'h4406
`define SDB_OFF_TXA_START 16'h4408
`define SDB_OFF_TXA_END 16'h440a
`define SDB_OFF_TXB_START 16'h440c
`define SDB_OFF_TXB_END 16'h440e
`define SDB_OFF_RXA_COUNT 16'h4410
`define SDB_OFF_RXB_COUNT 16'h4412
`define SDB_OFF_TX_COUNT 16'h4414
`define SDB_OFF_STATUS 16'h4416
`define SDB_OFF_RXA_ERR 16'h441a
`define SDB_OFF_RXB_ERR 16'h441c
`define SDB_OFF_CTRL 16'h4420
`define SDB_OFF_PENDING 16'h460e
`define SDB_OFF_ENABLE 16'h4626

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SDB_ADDR_TOP 3'b011
`define SDB_ZERO_TOP 3'b000
`define SDB_ADDR_RST 13'h0000
`define SDB_EV_RST 13'h0000
`define SDB_DATA_RST 16'h0000
`define SDB_BYTE_RST 8'h00
`define SDB_ONE_ADDR 13'h0001
`define SDB_CTL_RXLOAD_A 0
`define SDB_CTL_RXLOAD_B 1
`define SDB_CTL_TXLOAD_A 2
`define SDB_CTL_TXLOAD_B 3
`define SDB_CTL_RXRST 4
`define SDB_CTL_TXRST 5
`define SDB_EV_TXULD_B 12
`define SDB_EV_TXULD_A 11
`define SDB_EV_RXULD_B 10
`define SDB_EV_RXULD_A 9

`endif

// *** inc/sdb_pkg.sv ***
// Types shared by the serial DMA buffer block
package sdb_pkg;
    `include "sdb_cfg.svh"

    typedef logic [`SDB_AW-1:0] sdb_addr_t;

    // Byte from the serial engine with its error mark
    typedef struct packed {
        logic err;
        logic [`SDB_BW-1:0] data;
    } sdb_rxbyte_t;

    // Request on the system RAM port
    typedef struct packed {
        logic we;
        logic re;
        sdb_addr_t addr;
        logic [`SDB_BW-1:0] wdata;
    } sdb_ramreq_t;

    // Transmit fetch sequencer
    typedef enum logic [3:0] {
        SDB_TX_IDLE = 4'b0001,
        SDB_TX_FETCH = 4'b0010,
        SDB_TX_LATCH = 4'b0100,
        SDB_TX_HOLD = 4'b1000
    } sdb_txstate_t;
endpackage

// *** rtl/sdb_serial2_dma.sv ***
// Second serial controller double-buffered DMA with receive FIFO
`timescale 1ns/1ps
`include "sdb_cfg.svh"
// ----------------------------------------------------------------
// Receive byte FIFO
// ----------------------------------------------------------------
module sdb_fifo #(
    parameter int WIDTH = `SDB_FIFO_W,
    parameter int DEPTH = `SDB_FIFO_D,
    parameter int PW = `SDB_FIFO_PW
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [PW:0] next_count = count + {{PW{1'b0}}, push}
                             - {{PW{1'b0}}, pop};

    assign outData = mem[rdPtr];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            wrPtr <= push ? PW'(wrPtr + 1'b1) : wrPtr;
            rdPtr <= pop ? PW'(rdPtr + 1'b1) : rdPtr;
            count <= next_count;
            inReady <= next_count != (PW+1)'(DEPTH);
            outValid <= next_count != '0;
        end
    end
endmodule

// ----------------------------------------------------------------
// Buffer registers, DMA engines and interrupt flags
// ----------------------------------------------------------------
module sdb_serial2_dma (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [`SDB_DW-1:0] regAddr,
    input wire logic [`SDB_DW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`SDB_DW-1:0] regRdata,
    // Received bytes from the serial engine
    input wire logic rxValid,
    output logic rxReady,
    input wire sdb_pkg::sdb_rxbyte_t rxByte,
    // Bytes to transmit
    output logic txValid,
    input wire logic txReady,
    output logic [`SDB_BW-1:0] txData,
    // System RAM port
    output sdb_pkg::sdb_ramreq_t ramReq,
    input wire logic [`SDB_BW-1:0] ramRdata,
    // Serial engine events, one-cycle pulses, bits 8..0
    input wire logic [`SDB_NEXT-1:0] engineEvent,
    // Interrupt request
    output logic irq
);
    import sdb_pkg::*;

    function automatic sdb_addr_t bufAddr(input sdb_addr_t base,
                                          input sdb_addr_t offs);
        bufAddr = sdb_addr_t'(base + offs);
    endfunction

    function automatic logic [`SDB_DW-1:0] addrWord(input sdb_addr_t a);
        addrWord = {`SDB_ADDR_TOP, a};
    endfunction

    function automatic logic [`SDB_DW-1:0] roWord(input sdb_addr_t a);
        roWord = {`SDB_ZERO_TOP, a};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sdb_addr_t rxStart [2];
    sdb_addr_t rxEnd [2];
    sdb_addr_t txStart [2];
    sdb_addr_t txEnd [2];
    sdb_addr_t rxCount [2];
    sdb_addr_t rxErr [2];
    logic rxCapt [2];
    logic rxLoaded [2];
    logic txLoaded [2];
    logic rxSel;
    logic txSel;
    sdb_addr_t txCount;
    sdb_txstate_t txState;
    logic [`SDB_NEV-1:0] irqEnable;
    logic [`SDB_NEV-1:0] irqPending;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wrCtrl = regWrite && regAddr == `SDB_OFF_CTRL;
    wire wrPend = regWrite && regAddr == `SDB_OFF_PENDING;
    wire wrEn = regWrite && regAddr == `SDB_OFF_ENABLE;
    wire [1:0] wrRxStart = {regWrite && regAddr == `SDB_OFF_RXB_START,
                            regWrite && regAddr == `SDB_OFF_RXA_START};
    wire [1:0] wrRxEnd = {regWrite && regAddr == `SDB_OFF_RXB_END,
                          regWrite && regAddr == `SDB_OFF_RXA_END};
    wire [1:0] wrTxStart = {regWrite && regAddr == `SDB_OFF_TXB_START,
                            regWrite && regAddr == `SDB_OFF_TXA_START};
    wire [1:0] wrTxEnd = {regWrite && regAddr == `SDB_OFF_TXB_END,
                          regWrite && regAddr == `SDB_OFF_TXA_END};
    wire [1:0] rxLoadReq = {wrCtrl && regWdata[`SDB_CTL_RXLOAD_B],
                            wrCtrl && regWdata[`SDB_CTL_RXLOAD_A]};
    wire [1:0] txLoadReq = {wrCtrl && regWdata[`SDB_CTL_TXLOAD_B],
                            wrCtrl && regWdata[`SDB_CTL_TXLOAD_A]};
    wire rxReset = wrCtrl && regWdata[`SDB_CTL_RXRST];
    wire txReset = wrCtrl && regWdata[`SDB_CTL_TXRST];
    wire [`SDB_DW-1:0] statusWord = {{(`SDB_DW-4){1'b0}},
                                     txLoaded[1], txLoaded[0],
                                     rxLoaded[1], rxLoaded[0]};

    logic [`SDB_DW-1:0] next_regRdata;
    always_comb begin
        next_regRdata = `SDB_DATA_RST;
        if (!regRead) begin
            next_regRdata = `SDB_DATA_RST;
        end else if (regAddr == `SDB_OFF_RXA_START) begin
            next_regRdata = addrWord(rxStart[0]);
        end else if (regAddr == `SDB_OFF_RXA_END) begin
            next_regRdata = addrWord(rxEnd[0]);
        end else if (regAddr == `SDB_OFF_RXB_START) begin
            next_regRdata = addrWord(rxStart[1]);
        end else if (regAddr == `SDB_OFF_RXB_END) begin
            next_regRdata = addrWord(rxEnd[1]);
        end else if (regAddr == `SDB_OFF_TXA_START) begin
            next_regRdata = addrWord(txStart[0]);
        end else if (regAddr == `SDB_OFF_TXA_END) begin
            next_regRdata = addrWord(txEnd[0]);
        end else if (regAddr == `SDB_OFF_TXB_START) begin
            next_regRdata = addrWord(txStart[1]);
        end else if (regAddr == `SDB_OFF_TXB_END) begin
            next_regRdata = addrWord(txEnd[1]);
        end else if (regAddr == `SDB_OFF_RXA_COUNT) begin
            next_regRdata = roWord(rxCount[0]);
        end else if (regAddr == `SDB_OFF_RXB_COUNT) begin
            next_regRdata = roWord(rxCount[1]);
        end else if (regAddr == `SDB_OFF_TX_COUNT) begin
            next_regRdata = roWord(txCount);
        end else if (regAddr == `SDB_OFF_STATUS) begin
            next_regRdata = statusWord;
        end else if (regAddr == `SDB_OFF_RXA_ERR) begin
            next_regRdata = roWord(rxErr[0]);
        end else if (regAddr == `SDB_OFF_RXB_ERR) begin
            next_regRdata = roWord(rxErr[1]);
        end else if (regAddr == `SDB_OFF_PENDING) begin
            next_regRdata = roWord(irqPending);
        end else if (regAddr == `SDB_OFF_ENABLE) begin
            next_regRdata = roWord(irqEnable);
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    sdb_rxbyte_t fifoOut;
    logic fifoValid;
    wire rxBufOpen = rxLoaded[rxSel] && !rxReset;

    sdb_fifo #(
        .WIDTH(`SDB_FIFO_W),
        .DEPTH(`SDB_FIFO_D),
        .PW(`SDB_FIFO_PW)
    ) rxFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(rxValid),
        .inReady(rxReady),
        .inData(rxByte),
        .outValid(fifoValid),
        .outReady(rxBufOpen),
        .outData(fifoOut)
    );

    wire rxPop = fifoValid && rxBufOpen;
    wire [`SDB_AW-1:0] rxAddr = bufAddr(rxStart[rxSel], rxCount[rxSel]);
    wire rxLast = rxAddr == rxEnd[rxSel];
    wire rxUnload = rxPop && rxLast;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxSel <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                rxStart[i] <= `SDB_ADDR_RST;
                rxEnd[i] <= `SDB_ADDR_RST;
                rxCount[i] <= `SDB_ADDR_RST;
                rxErr[i] <= `SDB_ADDR_RST;
                rxCapt[i] <= 1'b0;
                rxLoaded[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wrRxStart[i]) begin
                    rxStart[i] <= regWdata[`SDB_AW-1:0];
                end
                if (wrRxEnd[i]) begin
                    rxEnd[i] <= regWdata[`SDB_AW-1:0];
                end
            end
            if (rxPop) begin
                if (fifoOut.err && !rxCapt[rxSel]) begin
                    rxErr[rxSel] <= rxCount[rxSel];
                    rxCapt[rxSel] <= 1'b1;
                end
                if (rxLast) begin
                    rxCount[rxSel] <= `SDB_ADDR_RST;
                    rxLoaded[rxSel] <= 1'b0;
                    rxSel <= ~rxSel;
                end else begin
                    rxCount[rxSel] <= bufAddr(rxCount[rxSel],
                                              `SDB_ONE_ADDR);
                end
            end
            for (int i = 0; i < 2; i++) begin
                if (rxLoadReq[i]) begin
                    rxLoaded[i] <= 1'b1;
                    rxCapt[i] <= 1'b0;
                    rxErr[i] <= `SDB_ADDR_RST;
                    rxCount[i] <= `SDB_ADDR_RST;
                end
            end
            if (rxReset) begin
                rxSel <= 1'b0;
                for (int i = 0; i < 2; i++) begin
                    rxLoaded[i] <= 1'b0;
                    rxCapt[i] <= 1'b0;
                    rxErr[i] <= `SDB_ADDR_RST;
                    rxCount[i] <= `SDB_ADDR_RST;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    wire [`SDB_AW-1:0] txAddr = bufAddr(txStart[txSel], txCount);
    wire txLast = txAddr == txEnd[txSel];
    wire txIssue = txState == SDB_TX_IDLE && txLoaded[txSel] && !rxPop
                   && !txReset;
    wire txDone = txState == SDB_TX_HOLD && txReady && !txReset;
    wire txUnload = txDone && txLast;

    sdb_txstate_t next_txState;
    always_comb begin
        next_txState = txState;
        case (txState)
            SDB_TX_IDLE: next_txState = txIssue ? SDB_TX_FETCH : SDB_TX_IDLE;
            SDB_TX_FETCH: next_txState = SDB_TX_LATCH;
            SDB_TX_LATCH: next_txState = SDB_TX_HOLD;
            SDB_TX_HOLD: next_txState = txReady ? SDB_TX_IDLE : SDB_TX_HOLD;
            default: next_txState = SDB_TX_IDLE;
        endcase
        if (txReset) begin
            next_txState = SDB_TX_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txState <= SDB_TX_IDLE;
            txSel <= 1'b0;
            txCount <= `SDB_ADDR_RST;
            txValid <= 1'b0;
            txData <= `SDB_BYTE_RST;
            for (int i = 0; i < 2; i++) begin
                txStart[i] <= `SDB_ADDR_RST;
                txEnd[i] <= `SDB_ADDR_RST;
                txLoaded[i] <= 1'b0;
            end
        end else begin
            txState <= next_txState;
            for (int i = 0; i < 2; i++) begin
                if (wrTxStart[i]) begin
                    txStart[i] <= regWdata[`SDB_AW-1:0];
                end
                if (wrTxEnd[i]) begin
                    txEnd[i] <= regWdata[`SDB_AW-1:0];
                end
            end
            if (txState == SDB_TX_LATCH) begin
                txData <= ramRdata;
                txValid <= 1'b1;
            end
            if (txDone) begin
                txValid <= 1'b0;
                if (txLast) begin
                    txCount <= `SDB_ADDR_RST;
                    txLoaded[txSel] <= 1'b0;
                    txSel <= ~txSel;
                end else begin
                    txCount <= bufAddr(txCount, `SDB_ONE_ADDR);
                end
            end
            for (int i = 0; i < 2; i++) begin
                if (txLoadReq[i]) begin
                    txLoaded[i] <= 1'b1;
                end
            end
            if (txReset) begin
                txSel <= 1'b0;
                txCount <= `SDB_ADDR_RST;
                txValid <= 1'b0;
                for (int i = 0; i < 2; i++) begin
                    txLoaded[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // RAM port
    // ------------------------------------------------------------
    sdb_ramreq_t next_ramReq;
    assign next_ramReq.we = rxPop;
    assign next_ramReq.re = txIssue;
    assign next_ramReq.addr = rxPop ? rxAddr : txAddr;
    assign next_ramReq.wdata = fifoOut.data;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ramReq <= '0;
        end else begin
            ramReq <= next_ramReq;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    wire [`SDB_NEV-1:0] eventVec = {txUnload && txSel,
                                    txUnload && !txSel,
                                    rxUnload && rxSel,
                                    rxUnload && !rxSel,
                                    engineEvent};
    wire [`SDB_NEV-1:0] next_irqPending =
        (irqPending & ~(wrPend ? regWdata[`SDB_NEV-1:0] : `SDB_EV_RST))
        | eventVec;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqEnable <= `SDB_EV_RST;
            irqPending <= `SDB_EV_RST;
            irq <= 1'b0;
            regRdata <= `SDB_DATA_RST;
        end else begin
            if (wrEn) begin
                irqEnable <= regWdata[`SDB_NEV-1:0];
            end
            irqPending <= next_irqPending;
            irq <= |(irqPending & irqEnable);
            regRdata <= next_regRdata;
        end
    end
endmodule

// *** rtl/sdb_fifo_unused_placeholder_none.sv ***
// Intentionally no logic; FIFO lives in the main design file
`timescale 1ns/1ps

// *** testbench/sdb_ram_model.sv ***
// System RAM model answering the block's byte requests
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module sdb_ram_model (
    // Clock
    input wire logic sys_clk,
    // Request and answer
    input wire sdb_pkg::sdb_ramreq_t ramReq,
    output logic [`SDB_BW-1:0] ramRdata
);
    import sdb_pkg::*;

    logic [`SDB_BW-1:0] mem [0:8191];

    initial ramRdata = 8'h00;

    // ------------------------------------------------------------
    // Storage and read port
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (ramReq.we) begin
            mem[ramReq.addr] <= ramReq.wdata;
        end
        if (ramReq.re) begin
            ramRdata <= mem[ramReq.addr];
        end else begin
            // Not held: stale data must not look valid
            ramRdata <= ~ramRdata;
        end
    end
endmodule

// *** testbench/sdb_dma_checker.sv ***
// Port assertions for the serial DMA buffer block
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module sdb_dma_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [`SDB_DW-1:0] regAddr,
    input wire logic [`SDB_DW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [`SDB_DW-1:0] regRdata,
    // Streams
    input wire logic rxValid,
    input wire logic rxReady,
    input wire sdb_pkg::sdb_rxbyte_t rxByte,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [`SDB_BW-1:0] txData,
    // RAM, events, interrupt
    input wire sdb_pkg::sdb_ramreq_t ramReq,
    input wire logic [`SDB_BW-1:0] ramRdata,
    input wire logic [`SDB_NEXT-1:0] engineEvent,
    input wire logic irq
);
    import sdb_pkg::*;

    logic [12:0] lastEn;
    wire enSel = regAddr == `SDB_OFF_ENABLE;
    wire errSel = regAddr == `SDB_OFF_RXA_ERR || regAddr == `SDB_OFF_RXB_ERR;
    wire bufSel = regAddr[15:4] == 12'h440 && !regAddr[0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lastEn <= 13'h0000;
        end else if (regWrite && enSel) begin
            lastEn <= regWdata[12:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!$past(regRead) |->
        regRdata == 16'h0000)
        else $error("read data not zero outside a read");
    addr_top_a: assert property (regRead && bufSel |=>
        regRdata[15:13] == 3'b011)
        else $error("address register upper bits wrong");
    enable_top_a: assert property (regRead && enSel |=>
        regRdata[15:13] == 3'b000)
        else $error("enable upper bits not zero");
    enable_value_a: assert property (regRead && enSel |=>
        regRdata[12:0] == lastEn)
        else $error("enable read differs from last write");
    err_top_a: assert property (regRead && errSel |=>
        regRdata[15:13] == 3'b000)
        else $error("error offset upper bits not zero");
    irq_masked_a: assert property (regWrite && enSel &&
        regWdata[12:0] == 13'h0000 |=> ##1 !irq)
        else $error("interrupt with all enables clear");
    ram_excl_a: assert property (!(ramReq.we && ramReq.re))
        else $error("RAM read and write together");
    tx_latency_a: assert property (ramReq.re |-> ##2 txValid)
        else $error("transmit byte late after fetch");
    tx_hold_a: assert property (txValid && !txReady |=>
        txValid && $stable(txData))
        else $error("transmit byte dropped before taken");
    tx_drop_a: assert property (txValid && txReady |=> !txValid)
        else $error("transmit valid held after taken");

    cover property (ramReq.we);
    cover property (ramReq.re);
    cover property (irq);
endmodule

bind sdb_serial2_dma sdb_dma_checker i_chk (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .ramReq(ramReq), .ramRdata(ramRdata), .engineEvent(engineEvent),
    .irq(irq)
);

// *** testbench/testbench.sv ***
// Self-checking bench for the serial DMA buffer block
`timescale 1ns/1ps
`include "sdb_cfg.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    fails++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
    end end

module testbench;
    import sdb_pkg::*;

    logic sys_clk = 0;
    logic rst = 1;
    logic [15:0] regAddr = 0, regWdata = 0, regRdata;
    logic regWrite = 0, regRead = 0, rxValid = 0, rxReady, txValid;
    logic txReady = 0, irq, rdPend = 0;
    sdb_rxbyte_t rxByte = '0;
    sdb_ramreq_t ramReq;
    logic [7:0] txData, ramRdata;
    logic [8:0] engineEvent = 0;
    int fails = 0, n_tests = 0, seed = 53652;
    logic [15:0] rdq[$];
    logic [20:0] ramq[$];
    logic [7:0] txq[$];
    logic [7:0] shadow [0:8191];
    logic [15:0] cfg [8] = '{16'h0100, 16'h0103, 16'h0200, 16'h0202,
        16'h0100, 16'h0101, 16'h0200, 16'h0200};

    always #25 sys_clk = ~sys_clk;

    sdb_serial2_dma i_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .rxValid(rxValid), .rxReady(rxReady),
        .rxByte(rxByte), .txValid(txValid), .txReady(txReady),
        .txData(txData), .ramReq(ramReq), .ramRdata(ramRdata),
        .engineEvent(engineEvent), .irq(irq));
    sdb_ram_model i_ram (.sys_clk(sys_clk), .ramReq(ramReq),
        .ramRdata(ramRdata));

    // ------------------------------------------------------------
    // Consumer stalls at random, monitor checks oldest notes
    // ------------------------------------------------------------
    always @(posedge sys_clk) txReady <= 1'($random(seed));

    always @(posedge sys_clk) begin : mon
        logic [15:0] e;
        logic [20:0] w;
        logic [7:0] t;
        rdPend <= regRead;
        if (rdPend) begin
            e = rdq.pop_front();
            `CHK(regRdata, e)
        end
        if (ramReq.we) begin
            w = ramq.pop_front();
            `CHK({ramReq.addr, ramReq.wdata}, w)
        end
        if (txValid && txReady) begin
            t = txq.pop_front();
            `CHK(txData, t)
        end
    end

    // ------------------------------------------------------------
    // Bus and stream tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1;
        @(posedge sys_clk);
        regWrite <= 0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1;
        rdq.push_back(x);
        @(posedge sys_clk);
        regRead <= 0;
    endtask

    task automatic snd(input logic e, input logic [12:0] a);
        logic [7:0] d;
        int k;
        d = 8'($random(seed));
        shadow[a] = d;
        ramq.push_back({a, d});
        @(posedge sys_clk);
        rxValid <= 1;
        rxByte <= {e, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rxReady !== 1'b1 && k < 200);
        rxValid <= 0;
        if (k == 200) begin
            fails++;
            stop_test();
        end
    endtask

    task automatic settle;
        int k;
        k = 0;
        while ((ramq.size() != 0 || txq.size() != 0) && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 400) begin
            fails++;
            stop_test();
        end
        repeat (3) @(posedge sys_clk);
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] v;
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        for (int a = 16'h4400; a <= 16'h440e; a += 2) begin
            rd(16'(a), 16'h6000);
        end
        rd(`SDB_OFF_RXA_ERR, 16'h0000);
        rd(`SDB_OFF_RXB_ERR, 16'h0000);
        rd(`SDB_OFF_ENABLE, 16'h0000);
        rd(16'h4500, 16'h0000);
        for (int a = 16'h4400; a <= 16'h440e; a += 2) begin
            v = 16'($random(seed));
            wr(16'(a), v);
            rd(16'(a), {3'b011, v[12:0]});
        end
        wr(`SDB_OFF_RXA_ERR, 16'hffff);
        rd(`SDB_OFF_RXA_ERR, 16'h0000);
        wr(`SDB_OFF_ENABLE, 16'hffff);
        rd(`SDB_OFF_ENABLE, 16'h1fff);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            wr(`SDB_OFF_ENABLE, 16'h01ff & ~(16'h1 << i));
            @(posedge sys_clk);
            engineEvent <= 9'(1 << i);
            @(posedge sys_clk);
            engineEvent <= 9'h000;
            repeat (3) @(posedge sys_clk);
            `CHK(irq, 1'b0)
            rd(`SDB_OFF_PENDING, 16'h1 << i);
            wr(`SDB_OFF_ENABLE, 16'h1 << i);
            repeat (3) @(posedge sys_clk);
            `CHK(irq, 1'b1)
            wr(`SDB_OFF_PENDING, 16'h1 << i);
            repeat (3) @(posedge sys_clk);
            `CHK(irq, 1'b0)
        end
        wr(`SDB_OFF_ENABLE, 16'h0000);
        $display("test events done");
        for (int i = 0; i < 8; i++) wr(16'h4400 + 16'(2 * i), cfg[i]);
        for (int i = 0; i < 4; i++) snd(i == 1 || i == 2, 13'h100 + 13'(i));
        repeat (4) @(posedge sys_clk);
        `CHK(rxReady, 1'b0)
        wr(`SDB_OFF_CTRL, 16'h0003);
        for (int i = 0; i < 3; i++) snd(i == 2, 13'h200 + 13'(i));
        settle();
        rd(`SDB_OFF_RXA_ERR, 16'h0001);
        rd(`SDB_OFF_RXB_ERR, 16'h0002);
        rd(`SDB_OFF_RXA_COUNT, 16'h0000);
        rd(`SDB_OFF_PENDING, 16'h0600);
        wr(`SDB_OFF_PENDING, 16'h0600);
        wr(`SDB_OFF_CTRL, 16'h0001);
        rd(`SDB_OFF_RXA_ERR, 16'h0000);
        for (int i = 0; i < 4; i++) snd(i == 3, 13'h100 + 13'(i));
        settle();
        rd(`SDB_OFF_RXA_ERR, 16'h0003);
        wr(`SDB_OFF_CTRL, 16'h0010);
        rd(`SDB_OFF_RXA_ERR, 16'h0000);
        $display("test receive done");
        txq.push_back(shadow[13'h100]);
        txq.push_back(shadow[13'h101]);
        txq.push_back(shadow[13'h200]);
        wr(`SDB_OFF_CTRL, 16'h000c);
        settle();
        rd(`SDB_OFF_PENDING, 16'h1a00);
        for (int i = 9; i < 13; i++) begin
            wr(`SDB_OFF_ENABLE, 16'h1 << i);
            repeat (3) @(posedge sys_clk);
            `CHK(irq, i != 10)
        end
        wr(`SDB_OFF_ENABLE, 16'h0000);
        repeat (3) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("test transmit done");
        stop_test();
    end
endmodule
